/* rtl/ulms_core.sv */
// Module: line/modem status, enhanced mode and scratchpad logic of the UART
//
// Contract
// RULE1 - Receive low a full frame sets break flag, one break char, held till high
// RULE2 - Non-FIFO: holding-empty sets on move to shifter, clears on host load
// RULE3 - FIFO: holding-empty set while transmit FIFO empty, else cleared
// RULE4 - Transmitter-empty set when FIFO and shifter both empty
// RULE5 - Error summary high while any receive FIFO byte carries an error
// RULE6 - CTS, DSR, CD deltas set on change; modem interrupt when enabled
// RULE7 - Ring delta only on ring input low-to-high; modem interrupt when enabled
// RULE8 - Auto CTS pauses transmit only after the current character completes
// RULE9 - Outside loopback upper modem bits are inverted pin levels
// RULE10 - Loopback: CTS=RTS bit, DSR=DTR bit, RI=bit 2, CD=bit 3
// RULE11 - Bits 4 and 5 disable transmitter and receiver when enhanced enabled
// RULE12 - Bit 6 selects 9-bit multidrop when enhanced enabled, default 0
// RULE13 - Bit 7 selects quarter-bit infrared pulses, else 3/16 pulses; code honours bit 7 only when enhanced enabled
// RULE14 - Scratchpad is 8-bit read/write, 0xFF after reset, kept in sleep
// RULE15 - With swap, scratchpad writes go to the enhanced mode register
// RULE16 - With swap, reads return FIFO count chosen by mode bits 1:0
// RULE17 - Alternate mode: first read gives receive count, then alternates
// RULE18 - Send-immediately routes next byte to shifter, clears after it is sent
// RULE19 - RS-485 mode: bit 3 sets request-to-send polarity during transmit/receive
// RULE20 - Hysteresis chosen by mode bits 5:4 with feature bits 1:0
// RULE21 - Modem control bit 4 selects internal loopback, default off
// RULE22 - Reading modem status clears all four delta flags
// RULE23 - Reserved low bits of the feature write are ignored
`timescale 1ns/1ps

module ulms_core (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire ulms_pkg::ulms_bus_t bus,
  output logic [7:0] rdata,
  input wire logic [7:0] modem_control,
  input wire logic [7:0] feature_control,
  input wire logic [7:0] enhanced_feature_control,
  input wire logic [7:0] interrupt_enable,
  input wire logic fifo_en,
  input wire logic [6:0] tx_fifo_count,
  input wire logic [6:0] rx_fifo_count,
  input wire logic [6:0] rx_err_count,
  input wire logic tx_shift_busy,
  input wire logic thr_load,
  input wire logic thr_to_shift,
  input wire logic tx_char_done,
  input wire logic bit_tick,
  input wire logic [3:0] frame_bits,
  input wire logic rx_pin,
  input wire ulms_pkg::ulms_modem_t modem_n_pin,
  output logic rx_push_valid,
  output logic [7:0] rx_push_data,
  input wire logic rx_push_ready,
  output logic tx_direct,
  output logic tx_pause,
  output logic tx_disable,
  output logic rx_disable,
  output logic nine_bit_mode,
  output logic fast_ir_mode,
  output logic rts_n_out,
  output logic [5:0] rts_hysteresis,
  output logic modem_irq
);

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 5'h1f;
      pin_s2_reg <= 5'h1f;
    end
    else if (ce)
    begin
      pin_s1_reg <= {rx_pin, modem_n_pin};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic rx_s;
  ulms_pkg::ulms_modem_t mpin_s;
  assign rx_s = pin_s2_reg[4];
  assign mpin_s = pin_s2_reg[3:0];

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic enh;
  logic swap;
  logic loop_en;
  logic rd_msr;
  logic rd_spr;
  logic wr_msr;
  logic wr_spr;
  logic wr_em;
  assign enh = enhanced_feature_control[ulms_pkg::EFC_ENH];
  assign swap = feature_control[ulms_pkg::FC_SWAP];
  assign loop_en = modem_control[ulms_pkg::MC_LOOP]; // RULE21
  assign rd_msr = ce && bus.rd && bus.addr == ulms_pkg::ADDR_MODEM_STATUS;
  assign rd_spr = ce && bus.rd && bus.addr == ulms_pkg::ADDR_SCRATCHPAD;
  assign wr_msr = ce && bus.wr && bus.addr == ulms_pkg::ADDR_MODEM_STATUS;
  assign wr_spr = ce && bus.wr && bus.addr == ulms_pkg::ADDR_SCRATCHPAD && !swap;
  assign wr_em = ce && bus.wr && bus.addr == ulms_pkg::ADDR_SCRATCHPAD && swap; // RULE15

  // ----------------------------------------
  // Modem status
  // ----------------------------------------
  ulms_pkg::ulms_modem_t mstat;
  ulms_pkg::ulms_modem_t mprev_reg;
  ulms_pkg::ulms_modem_t delta_reg;
  ulms_pkg::ulms_modem_t delta_set;
  always_comb
  begin
    if (loop_en)
    begin
      mstat.cts = modem_control[ulms_pkg::MC_RTS]; // RULE10
      mstat.dsr = modem_control[ulms_pkg::MC_DTR]; // RULE10
      mstat.ri = modem_control[ulms_pkg::MC_OUT1]; // RULE10
      mstat.cd = modem_control[ulms_pkg::MC_OUT2]; // RULE10
    end
    else
    begin
      mstat = ~mpin_s; // RULE9
    end
  end

  always_comb
  begin
    delta_set.cts = mstat.cts != mprev_reg.cts; // RULE6
    delta_set.dsr = mstat.dsr != mprev_reg.dsr; // RULE6
    delta_set.cd = mstat.cd != mprev_reg.cd; // RULE6
    delta_set.ri = mprev_reg.ri && !mstat.ri; // RULE7
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) mprev_reg <= 4'h0;
    else if (ce) mprev_reg <= mstat;
  end
  // Set wins over the read clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) delta_reg <= 4'h0;
    else if (ce) delta_reg <= (rd_msr ? 4'h0 : delta_reg) | delta_set; // RULE22
  end
  assign modem_irq = interrupt_enable[ulms_pkg::IE_MODEM] && (|delta_reg); // RULE6 RULE7

  // ----------------------------------------
  // Write-only feature enables
  // ----------------------------------------
  logic [7:4] feat_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) feat_reg <= ulms_pkg::FEAT_RESET[7:4];
    else if (wr_msr) feat_reg <= bus.wdata[7:4]; // RULE23
  end
  assign tx_disable = enh && feat_reg[ulms_pkg::LFE_TX_DIS]; // RULE11
  assign rx_disable = enh && feat_reg[ulms_pkg::LFE_RX_DIS]; // RULE11
  assign nine_bit_mode = enh && feat_reg[ulms_pkg::LFE_NINE]; // RULE12
  assign fast_ir_mode = enh && feat_reg[ulms_pkg::LFE_FAST_IR]; // RULE13

  // ----------------------------------------
  // Scratchpad and enhanced mode select
  // ----------------------------------------
  logic [7:0] scratch_reg;
  logic [7:0] emode_reg;
  logic alt_tx_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) scratch_reg <= ulms_pkg::SCRATCH_RESET; // RULE14
    else if (wr_spr) scratch_reg <= bus.wdata; // RULE14
  end
  logic tx_direct_pend_reg;
  logic send_clear;
  assign send_clear = tx_char_done && tx_direct_pend_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) emode_reg <= ulms_pkg::EMODE_RESET;
    else if (wr_em) emode_reg <= bus.wdata;
    else if (ce && send_clear) emode_reg[ulms_pkg::EM_SEND_NOW] <= 1'b0; // RULE18
  end
  ulms_pkg::ulms_cnt_mode_t cnt_mode;
  always_comb
  begin
    case (emode_reg[1:0])
      2'b01: cnt_mode = ulms_pkg::ULMS_CNT_TX; // RULE16
      2'b11: cnt_mode = ulms_pkg::ULMS_CNT_ALT; // RULE16
      default: cnt_mode = ulms_pkg::ULMS_CNT_RX; // RULE16
    endcase
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) alt_tx_reg <= 1'b0;
    else if (wr_em) alt_tx_reg <= 1'b0; // RULE17
    else if (rd_spr && swap && cnt_mode == ulms_pkg::ULMS_CNT_ALT) alt_tx_reg <= !alt_tx_reg; // RULE17
  end
  logic [7:0] count_sel;
  always_comb
  begin
    case (cnt_mode)
      ulms_pkg::ULMS_CNT_TX: count_sel = {1'b0, tx_fifo_count};
      ulms_pkg::ULMS_CNT_ALT: count_sel = alt_tx_reg ? {1'b0, tx_fifo_count}
                                                     : {1'b0, rx_fifo_count};
      default: count_sel = {1'b0, rx_fifo_count};
    endcase
  end

  // ----------------------------------------
  // Send immediately, auto CTS, RS-485 and hysteresis
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) tx_direct_pend_reg <= 1'b0;
    else if (ce && thr_load && fifo_en && emode_reg[ulms_pkg::EM_SEND_NOW]) tx_direct_pend_reg <= 1'b1;
    else if (ce && tx_char_done) tx_direct_pend_reg <= 1'b0;
  end
  assign tx_direct = thr_load && fifo_en && emode_reg[ulms_pkg::EM_SEND_NOW] // RULE18
                     && !tx_direct_pend_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) tx_pause <= 1'b0;
    else if (ce && (!tx_shift_busy || tx_char_done)) // RULE8
      tx_pause <= enhanced_feature_control[ulms_pkg::EFC_AUTO_CTS] && !mstat.cts; // RULE8
  end
  logic rs485_tx;
  assign rs485_tx = tx_shift_busy || tx_fifo_count != 7'h00;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) rts_n_out <= 1'b1;
    else if (ce)
    begin
      if (feature_control[ulms_pkg::FC_RS485])
        rts_n_out <= rs485_tx ? emode_reg[ulms_pkg::EM_RTS_INV]
                              : !emode_reg[ulms_pkg::EM_RTS_INV]; // RULE19
      else
        rts_n_out <= !modem_control[ulms_pkg::MC_RTS];
    end
  end
  assign rts_hysteresis = ulms_pkg::ulms_hyst({emode_reg[ulms_pkg::EM_HYST_HI:ulms_pkg::EM_HYST_LO],
                                              feature_control[1:0]}); // RULE20

  // ----------------------------------------
  // Break detection and break character buffer
  // ----------------------------------------
  logic [3:0] brk_cnt_reg;
  logic brk_flag_reg;
  logic brk_push;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) brk_cnt_reg <= 4'h0;
    else if (ce && rx_s) brk_cnt_reg <= 4'h0;
    else if (ce && bit_tick && brk_cnt_reg != frame_bits) brk_cnt_reg <= brk_cnt_reg + 4'h1;
  end
  assign brk_push = ce && !rx_s && !brk_flag_reg && brk_cnt_reg == frame_bits
                    && frame_bits != 4'h0;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) brk_flag_reg <= 1'b0;
    else if (ce && rx_s) brk_flag_reg <= 1'b0; // RULE1
    else if (brk_push) brk_flag_reg <= 1'b1; // RULE1
  end

  logic [7:0] buf_mem [2];
  logic [1:0] buf_cnt_reg;
  logic buf_wp_reg;
  logic buf_rp_reg;
  logic buf_in_ready;
  logic buf_pop;
  logic buf_push;
  assign buf_in_ready = buf_cnt_reg != 2'h2;
  assign buf_push = brk_push && buf_in_ready; // RULE1
  assign buf_pop = ce && rx_push_valid && rx_push_ready;
  assign rx_push_valid = buf_cnt_reg != 2'h0;
  assign rx_push_data = buf_mem[buf_rp_reg];
  always_ff @(posedge clock)
  begin
    if (buf_push) buf_mem[buf_wp_reg] <= ulms_pkg::BREAK_CHAR;
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_cnt_reg <= 2'h0;
      buf_wp_reg <= 1'b0;
      buf_rp_reg <= 1'b0;
    end
    else
    begin
      if (buf_push) buf_wp_reg <= !buf_wp_reg;
      if (buf_pop) buf_rp_reg <= !buf_rp_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ----------------------------------------
  // Line status
  // ----------------------------------------
  logic thre_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) thre_reg <= 1'b1;
    else if (ce && thr_load) thre_reg <= 1'b0; // RULE2
    else if (ce && thr_to_shift) thre_reg <= 1'b1; // RULE2
  end
  logic thre;
  logic temt;
  logic [7:0] line_status;
  assign thre = fifo_en ? (tx_fifo_count == 7'h00) : thre_reg; // RULE3
  assign temt = thre && !tx_shift_busy; // RULE4
  assign line_status = {rx_err_count != 7'h00, temt, thre, brk_flag_reg, 4'h0}; // RULE5

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) rdata <= ulms_pkg::BYTE_ZERO;
    else if (ce && bus.rd)
    begin
      case (bus.addr)
        ulms_pkg::ADDR_LINE_STATUS: rdata <= line_status;
        ulms_pkg::ADDR_MODEM_STATUS: rdata <= {mstat, delta_reg};
        ulms_pkg::ADDR_SCRATCHPAD: rdata <= swap ? count_sel : scratch_reg; // RULE16 RULE14
        default: rdata <= ulms_pkg::BYTE_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  brk_one_char_a: assert property (buf_push |=> !buf_push [*2]) else $error("break pushed twice"); // RULE1
  brk_hold_a: assert property (ce && rx_s |=> !brk_flag_reg) else $error("break held past idle"); // RULE1
  thre_nofifo_a: assert property (ce && !fifo_en && thr_load |=> !thre_reg) else $error("thre not cleared"); // RULE2
  thre_fifo_a: assert property (fifo_en |-> thre == (tx_fifo_count == 7'h00)) else $error("thre vs fifo"); // RULE3
  temt_flag_a: assert property (tx_shift_busy |-> !temt) else $error("temt while shifting"); // RULE4
  err_sum_a: assert property ((rx_err_count != 7'h00) |-> line_status[7]) else $error("error summary low"); // RULE5
  delta_cts_a: assert property (ce && delta_set.cts |=> delta_reg.cts) else $error("cts delta lost"); // RULE6
  ri_edge_a: assert property (ce && !mprev_reg.ri && mstat.ri && !delta_reg.ri |=> !delta_reg.ri || $past(delta_set.ri)) else $error("ri rise flagged"); // RULE7
  cts_mid_a: assert property (ce && tx_shift_busy && !tx_char_done |=> $stable(tx_pause)) else $error("pause mid char"); // RULE8
  loop_src_a: assert property (loop_en |-> mstat.cd == modem_control[3]) else $error("loop cd source"); // RULE10
  msr_clear_a: assert property (rd_msr && !(|delta_set) |=> delta_reg == 4'h0) else $error("delta not cleared"); // RULE22
  txdis_a: assert property (!enh |-> !tx_disable && !nine_bit_mode) else $error("enable without enh"); // RULE11
  alt_first_a: assert property (wr_em |=> !alt_tx_reg) else $error("alt not rx first"); // RULE17

  brk_seen_c: cover property (buf_push);
  alt_read_c: cover property (rd_spr && swap && cnt_mode == ulms_pkg::ULMS_CNT_ALT && alt_tx_reg);
  send_now_c: cover property (send_clear);
  ri_delta_c: cover property (delta_set.ri);

endmodule : ulms_core

/* rtl/ulms_pkg.sv */
// Package: register map, field positions and types for the UART status block
package ulms_pkg;

  // ----------------------------------------
  // Register addresses on the host port
  // ----------------------------------------
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [2:0] ADDR_SCRATCHPAD = 3'h7;

  // ----------------------------------------
  // Reset values and constants
  // ----------------------------------------
  localparam logic [7:0] SCRATCH_RESET = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BREAK_CHAR = 8'h00;
  localparam logic [7:0] FEAT_RESET = 8'h00;
  localparam logic [7:0] EMODE_RESET = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int LFE_TX_DIS = 4;
  localparam int LFE_RX_DIS = 5;
  localparam int LFE_NINE = 6;
  localparam int LFE_FAST_IR = 7;
  localparam int EM_SEND_NOW = 2;
  localparam int EM_RTS_INV = 3;
  localparam int EM_HYST_LO = 4;
  localparam int EM_HYST_HI = 5;
  localparam int EFC_ENH = 4;
  localparam int EFC_AUTO_CTS = 7;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int FC_RS485 = 3;
  localparam int FC_SWAP = 6;
  localparam int IE_MODEM = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ulms_bus_t;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } ulms_modem_t;

  typedef enum logic [1:0] {
    ULMS_CNT_RX,
    ULMS_CNT_TX,
    ULMS_CNT_ALT
  } ulms_cnt_mode_t;

  // Hysteresis in characters, index {emode[5:4], feature[1:0]}
  function automatic logic [5:0] ulms_hyst(input logic [3:0] sel);
    logic [5:0] h;
    h = 6'h00;
    case (sel)
      4'h0: h = 6'h00;
      4'h1: h = 6'h04;
      4'h2: h = 6'h06;
      4'h3: h = 6'h08;
      4'h4: h = 6'h08;
      4'h5: h = 6'h10;
      4'h6: h = 6'h18;
      4'h7: h = 6'h20;
      4'h8: h = 6'h28;
      4'h9: h = 6'h2c;
      4'ha: h = 6'h30;
      4'hb: h = 6'h34;
      4'hc: h = 6'h0c;
      4'hd: h = 6'h14;
      4'he: h = 6'h1c;
      default: h = 6'h24;
    endcase
    return h;
  endfunction : ulms_hyst

endpackage : ulms_pkg

/* dv/ulms_remote_model.sv */
// Model of the remote modem driving the serial line and handshake pins
`timescale 1ns/1ps

module ulms_remote_model (
  input wire logic clock,
  output ulms_pkg::ulms_modem_t modem_n_pin,
  output logic rx_pin,
  input wire logic rx_push_valid,
  input wire logic [7:0] rx_push_data,
  output logic rx_push_ready
);
  int pops = 0;
  logic [7:0] last_pop = 8'hff;

  initial
  begin
    modem_n_pin = 4'hf;
    rx_pin = 1'b1;
    rx_push_ready = 1'b0;
  end

  // ----------------------------------------
  // Handshake pins, CTS high pauses the far transmitter
  // ----------------------------------------
  task automatic set_line(input logic [3:0] pins);
    @(posedge clock);
    modem_n_pin <= pins;
  endtask : set_line

  task automatic drive_rx(input logic lvl);
    @(posedge clock);
    rx_pin <= lvl;
  endtask : drive_rx

  // ----------------------------------------
  // Break sink, may stall
  // ----------------------------------------
  task automatic sink(input logic rdy);
    @(posedge clock);
    rx_push_ready <= rdy;
  endtask : sink

  always @(posedge clock)
  begin
    if (rx_push_valid && rx_push_ready)
    begin
      pops <= pops + 1;
      last_pop <= rx_push_data;
    end
  end
endmodule : ulms_remote_model

/* dv/tb_top.sv */
// Self-checking bench for the UART status and enhanced mode block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end

module tb_top;
  logic clock = 0;
  logic arst_n = 0;
  logic ce = 1;
  ulms_pkg::ulms_bus_t bus = '0;
  logic [7:0] rdata, rv;
  logic [7:0] modem_control = 8'h00;
  logic [7:0] feature_control = 8'h00;
  logic [7:0] enhanced_feature_control = 8'h00;
  logic [7:0] interrupt_enable = 8'h08;
  logic fifo_en = 1;
  logic [6:0] tx_fifo_count = 7'h00, rx_fifo_count = 7'h00, rx_err_count = 7'h00;
  logic tx_shift_busy = 0, thr_load = 0, thr_to_shift = 0, tx_char_done = 0, bit_tick = 0;
  logic [3:0] frame_bits = 4'ha;
  logic [1:0] tcnt = 2'h0;
  logic rx_pin, rx_push_valid, rx_push_ready, tx_direct, tx_pause, tx_disable, rx_disable;
  logic nine_bit_mode, fast_ir_mode, rts_n_out, modem_irq;
  logic [7:0] rx_push_data;
  logic [5:0] rts_hysteresis;
  logic [3:0] p;
  ulms_pkg::ulms_modem_t modem_n_pin;
  int mismatches = 0;
  int compares = 0;
  logic [5:0] hy [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
                          6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};

  always #2.5 clock = ~clock;

  always @(posedge clock)
  begin
    tcnt <= tcnt + 2'h1;
    bit_tick <= (tcnt == 2'h3);
  end

  ulms_core dut (.clock, .arst_n, .ce, .bus, .rdata, .modem_control, .feature_control,
    .enhanced_feature_control, .interrupt_enable, .fifo_en, .tx_fifo_count, .rx_fifo_count,
    .rx_err_count, .tx_shift_busy, .thr_load, .thr_to_shift, .tx_char_done, .bit_tick,
    .frame_bits, .rx_pin, .modem_n_pin, .rx_push_valid, .rx_push_data, .rx_push_ready,
    .tx_direct, .tx_pause, .tx_disable, .rx_disable, .nine_bit_mode, .fast_ir_mode,
    .rts_n_out, .rts_hysteresis, .modem_irq);

  ulms_remote_model remote (.clock, .modem_n_pin, .rx_pin, .rx_push_valid, .rx_push_data,
    .rx_push_ready);

  // ----------------------------------------
  // Host access tasks
  // ----------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clock);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
    rv = rdata;
  endtask : rd

  task automatic load(input logic exp);
    @(posedge clock);
    thr_load <= 1'b1;
    @(posedge clock);
    `CHK("tx_direct", exp, tx_direct)
    thr_load <= 1'b0;
  endtask : load

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  initial
  begin
    wt(20000);
    mismatches++;
    test_done;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    wt(4);
    arst_n <= 1'b1;
    wt(4);
    rd(3'h7); `CHK("scratch_rst", 8'hff, rv)
    rd(3'h5); `CHK("lsr_idle", 8'h60, rv)
    rd(3'h0); `CHK("unmapped", 8'h00, rv)
    wr(3'h7, 8'h5a);
    rd(3'h7); `CHK("scratch_rw", 8'h5a, rv)
    ce <= 1'b0;
    wr(3'h7, 8'h33);
    ce <= 1'b1;
    rd(3'h7); `CHK("ce_freeze", 8'h5a, rv)
    tx_fifo_count <= 7'h01;
    rd(3'h5); `CHK("lsr_fifo1", 2'h0, rv[6:5])
    tx_fifo_count <= 7'h00;
    tx_shift_busy <= 1'b1;
    rx_err_count <= 7'h01;
    rd(3'h5); `CHK("lsr_busy", 3'h5, rv[7:5])
    rx_err_count <= 7'h00;
    tx_shift_busy <= 1'b0;
    rd(3'h5); `CHK("lsr_err_clr", 1'b0, rv[7])
    fifo_en <= 1'b0;
    load(1'b0);
    rd(3'h5); `CHK("thre_load", 1'b0, rv[5])
    @(posedge clock) thr_to_shift <= 1'b1;
    @(posedge clock) thr_to_shift <= 1'b0;
    rd(3'h5); `CHK("thre_move", 1'b1, rv[5])
    fifo_en <= 1'b1;
    // Break held low, sink stalling first
    frame_bits <= 4'hb;
    remote.drive_rx(1'b0);
    wt(70);
    rd(3'h5); `CHK("brk_set", 1'b1, rv[4])
    `CHK("brk_valid", 1'b1, rx_push_valid)
    remote.sink(1'b1);
    wt(70);
    `CHK("brk_pops", 1, remote.pops)
    `CHK("brk_char", 8'h00, remote.last_pop)
    remote.drive_rx(1'b1);
    wt(6);
    rd(3'h5); `CHK("brk_clr", 1'b0, rv[4])
    // Modem pins, one at a time low then high
    rd(3'h6);
    p = 4'hf;
    for (int i = 0; i < 4; i++)
    begin
      p[i] = 1'b0;
      remote.set_line(p);
      wt(4);
      `CHK("irq_on", (i != 2), modem_irq)
      rd(3'h6); `CHK("msr_fall", {~p, (i == 2) ? 4'h0 : 4'h1 << i}, rv)
      p[i] = 1'b1;
      remote.set_line(p);
      wt(4);
      rd(3'h6); `CHK("msr_rise", {~p, 4'h1 << i}, rv)
    end
    rd(3'h6); `CHK("msr_rdclr", 8'h00, rv)
    `CHK("irq_off", 1'b0, modem_irq)
    interrupt_enable <= 8'h00;
    remote.set_line(4'he);
    wt(4);
    `CHK("irq_mask", 1'b0, modem_irq)
    rd(3'h6); `CHK("msr_inv", 8'h11, rv)
    // Loopback sources
    for (int i = 0; i < 4; i++)
    begin
      modem_control <= 8'h10 | (8'h01 << (i == 0 ? 1 : i == 1 ? 0 : i));
      wt(3);
      rd(3'h6); `CHK("loop_msr", 4'h1 << i, rv[7:4])
    end
    modem_control <= 8'h10;
    wt(3);
    rd(3'h6); `CHK("loop_none", 4'h0, rv[7:4])
    modem_control <= 8'h00;
    // Feature enables gated by enhanced bit
    wr(3'h6, 8'hf0);
    wt(1);
    `CHK("feat_gated", 4'h0, {fast_ir_mode, nine_bit_mode, rx_disable, tx_disable})
    enhanced_feature_control <= 8'h10;
    wt(1);
    `CHK("feat_all", 4'hf, {fast_ir_mode, nine_bit_mode, rx_disable, tx_disable})
    wr(3'h6, 8'h5f);
    wt(1);
    `CHK("feat_mix", 4'h5, {fast_ir_mode, nine_bit_mode, rx_disable, tx_disable})
    wr(3'h6, 8'h0f);
    wt(1);
    `CHK("feat_resv", 4'h0, {fast_ir_mode, nine_bit_mode, rx_disable, tx_disable})
    // Swap: level counters
    feature_control <= 8'h40;
    rx_fifo_count <= 7'h05;
    tx_fifo_count <= 7'h09;
    wr(3'h7, 8'h00);
    rd(3'h7); `CHK("cnt_rx", 8'h05, rv)
    wr(3'h7, 8'h01);
    rd(3'h7); `CHK("cnt_tx", 8'h09, rv)
    wr(3'h7, 8'h03);
    rd(3'h7); `CHK("alt_1", 8'h05, rv)
    rd(3'h7); `CHK("alt_2", 8'h09, rv)
    rd(3'h7); `CHK("alt_3", 8'h05, rv)
    // Hysteresis codes
    for (int s = 0; s < 16; s++)
    begin
      feature_control <= {6'h10, s[1:0]};
      wr(3'h7, {2'h0, s[3:2], 4'h0});
      wt(1);
      `CHK("hyst", hy[s], rts_hysteresis)
    end
    // Send immediately, one byte only
    tx_fifo_count <= 7'h00;
    wr(3'h7, 8'h04);
    load(1'b1);
    load(1'b0);
    @(posedge clock) tx_char_done <= 1'b1;
    @(posedge clock) tx_char_done <= 1'b0;
    load(1'b0);
    // RS-485 direction polarity
    feature_control <= 8'h48;
    for (int v = 0; v < 2; v++)
    begin
      wr(3'h7, v[0] ? 8'h08 : 8'h00);
      tx_shift_busy <= 1'b1;
      wt(3);
      `CHK("rts_tx", v[0], rts_n_out)
      tx_shift_busy <= 1'b0;
      wt(3);
      `CHK("rts_rx", ~v[0], rts_n_out)
    end
    feature_control <= 8'h00;
    rd(3'h7); `CHK("swap_keep", 8'h5a, rv)
    // Auto CTS waits for the character in progress
    enhanced_feature_control <= 8'h80;
    tx_shift_busy <= 1'b1;
    wt(3);
    remote.set_line(4'hf);
    wt(6);
    `CHK("cts_hold", 1'b0, tx_pause)
    @(posedge clock) tx_char_done <= 1'b1;
    @(posedge clock) tx_char_done <= 1'b0;
    wt(2);
    `CHK("cts_stop", 1'b1, tx_pause)
    tx_shift_busy <= 1'b0;
    remote.set_line(4'he);
    wt(6);
    `CHK("cts_go", 1'b0, tx_pause)
    test_done;
  end
endmodule : tb_top
